// *** hw/sideband_audio_params.svh ***
`ifndef SIDEBAND_AUDIO_PARAMS_SVH
`define SIDEBAND_AUDIO_PARAMS_SVH
// register offsets (byte addresses)
`define OFS_SB_COMMAND      12'h100
`define OFS_SB_TARGET_ADDR  12'h108
`define OFS_STREAM_MISC     12'h184
`define OFS_VID_M           12'h1c0
`define OFS_VID_N           12'h1c4
`define OFS_AUDIO_CONTROL   12'h300
`define OFS_AUDIO_CHANNELS  12'h304
`define OFS_AUDIO_M         12'h328
`define OFS_AUDIO_N         12'h32c
`define OFS_INT_STATUS      12'h140
`define OFS_HPD_STATE       12'h144
// command register fields
`define CMD_LEN_LSB         0
`define CMD_LEN_MSB         3
`define CMD_CODE_LSB        8
`define CMD_CODE_MSB        11
`define CMD_ADDR_ONLY_BIT   12
`define CMD_MOT_BIT         10
// interrupt status bits
`define INT_SINK_IRQ_BIT    0
`define INT_HOTPLUG_CHANGE_EVENT_BIT   1
// fixed video n in asynchronous mode
`define VID_N_ASYNC         24'h008000
// hot-plug timing in microseconds; clock rate in MHz
`define HPD_SAMPLE_US       300
`define HPD_IRQ_MIN_US      500
`define HPD_IRQ_MAX_US      1000
`define HPD_DISC_US         2000
`define CLK_MHZ             20
// secondary packet geometry: sizes in bytes, then samples per packet
`define PKT_HDR_BYTES       4
`define PKT_HDR_PAR_BYTES   4
`define PKT_PAY_BYTES       32
`define PKT_PAY_PAR_BYTES   8
`define SAMPLES_PER_PKT     8
`endif

// *** hw/sideband_audio_pkg.sv ***
package sideband_audio_pkg;
  // register bus request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } reg_req_t;
  // sideband request handed to the aux engine
  typedef struct packed {
    logic        addr_only;
    logic        middle_of_transfer_flag;
    logic [2:0]  kind;
    logic [3:0]  len;
    logic [31:0] target;
  } sb_req_t;
  // hot-plug classifier states
  typedef enum logic [2:0] {
    HP_HIGH = 3'b001,
    HP_LOW  = 3'b010,
    HP_GONE = 3'b100
  } hp_state_t;
endpackage

// *** hw/hotplug_classifier.sv ***
`timescale 1ns/1ns
`include "sideband_audio_params.svh"
module hotplug_classifier
  import sideband_audio_pkg::*;
#(
  parameter int CLK_MHZ = `CLK_MHZ
)(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic srst,
  // synchronised level
  input  wire logic hpd_sync,
  // classified events
  output logic      irq_pulse,
  output logic      disc_pulse,
  output logic      conn_pulse
);
  // cycles per sample tick, longer than 250 us
  localparam int SAMP_CYC = `HPD_SAMPLE_US * CLK_MHZ;
  localparam int IRQ_MIN  = (`HPD_IRQ_MIN_US + `HPD_SAMPLE_US - 1) / `HPD_SAMPLE_US;
  localparam int IRQ_MAX  = `HPD_IRQ_MAX_US / `HPD_SAMPLE_US + 1;
  localparam int DISC_CNT = `HPD_DISC_US / `HPD_SAMPLE_US + 1;
  // the tick counter is 16 bits wide, so the rate is bounded on both sides
  if (CLK_MHZ < 1 || SAMP_CYC > 65536) $error("clock rate out of range for tick counter");

  logic [15:0] tick_r, tick_nxt;
  logic [3:0]  low_r, low_nxt;
  hp_state_t   st_r, st_nxt;
  logic        irq_nxt, disc_nxt, conn_nxt;

  // sampled debouncer; width counted in ticks of the fixed clock
  always_comb
  begin
    tick_nxt = tick_r + 16'h0001;
    low_nxt  = low_r;
    st_nxt   = st_r;
    irq_nxt  = 1'b0;
    disc_nxt = 1'b0;
    conn_nxt = 1'b0;
    if (tick_r == 16'(SAMP_CYC - 1))
    begin
      tick_nxt = 16'h0000;
      case (st_r)
        HP_HIGH:
          if (!hpd_sync)
          begin
            st_nxt  = HP_LOW;
            low_nxt = 4'h1;
          end
        HP_LOW:
          if (hpd_sync)
          begin
            st_nxt  = HP_HIGH;
            irq_nxt = (low_r >= 4'(IRQ_MIN)) && (low_r <= 4'(IRQ_MAX));
          end
          else if (low_r == 4'(DISC_CNT))
          begin
            st_nxt   = HP_GONE;
            disc_nxt = 1'b1;
          end
          else
            low_nxt = low_r + 4'h1;
        HP_GONE:
          if (hpd_sync)
          begin
            st_nxt   = HP_HIGH;
            conn_nxt = 1'b1;
          end
        default: st_nxt = HP_GONE;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      tick_r     <= 16'h0000;
      low_r      <= 4'h0;
      st_r       <= HP_GONE;
      irq_pulse  <= 1'b0;
      disc_pulse <= 1'b0;
      conn_pulse <= 1'b0;
    end
    else
    begin
      tick_r     <= tick_nxt;
      low_r      <= low_nxt;
      st_r       <= st_nxt;
      irq_pulse  <= irq_nxt;
      disc_pulse <= disc_nxt;
      conn_pulse <= conn_nxt;
    end
  end

  a_no_double_evt: assert property (@(posedge sys_clk) disable iff (srst)
    !(irq_pulse && disc_pulse)) else $error("irq and disconnect together");
endmodule

// *** hw/source_sideband_audio_ctrl.sv ***
`timescale 1ns/1ns
`include "sideband_audio_params.svh"
module source_sideband_audio_ctrl
  import sideband_audio_pkg::*;
#(
  parameter int CLK_MHZ = `CLK_MHZ,
  parameter int BUF_DEPTH = `SAMPLES_PER_PKT
)(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // register port
  input  wire reg_req_t    reg_req,
  output logic [31:0]      reg_rdata,
  // sideband request toward the aux engine
  output logic             sb_req_valid,
  output sb_req_t          sb_req,
  // video clocking
  input  wire logic [23:0] clk_if_vid_m,
  output logic [23:0]      tx_vid_m,
  output logic [23:0]      tx_vid_n,
  // hot-plug pin and events
  input  wire logic        hpd_pin,
  output logic             hotplug_change_event,
  output logic             hpd_level,
  // audio stream ingress
  input  wire logic        aud_tvalid,
  input  wire logic [31:0] aud_tdata,
  output logic             aud_tready,
  // secondary packet bytes out
  input  wire logic        pkt_ready,
  output logic             pkt_valid,
  output logic [7:0]       pkt_byte,
  output logic             pkt_first,
  output logic             audio_mute
);
  localparam int PKT_LEN = `PKT_HDR_BYTES + `PKT_HDR_PAR_BYTES
                         + `PKT_PAY_BYTES + `PKT_PAY_PAR_BYTES;
  // the sample index and byte counters are sized for exactly one packet
  if (BUF_DEPTH != `SAMPLES_PER_PKT) $error("buffer must hold one packet");

  // ==========================================================
  // registers
  logic [31:0] cmd_r, cmd_nxt, tgt_r, tgt_nxt, misc_r, misc_nxt;
  logic [23:0] vm_r, vm_nxt, vn_r, vn_nxt, am_r, am_nxt, an_r, an_nxt;
  logic [7:0]  actl_r, actl_nxt;
  logic [2:0]  ach_r, ach_nxt;
  logic [1:0]  ist_r, ist_nxt;
  logic        sbv_nxt;
  logic [31:0] rd_nxt;
  logic        irq_p, disc_p, conn_p, chg_nxt;
  logic        hs1_r, hs2_r;

  // two-flop synchroniser for the hot-plug pin
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      hs1_r <= 1'b0;
      hs2_r <= 1'b0;
    end
    else
    begin
      hs1_r <= hpd_pin;
      hs2_r <= hs1_r;
    end
  end

  hotplug_classifier #(.CLK_MHZ(CLK_MHZ)) u_hpd (
    .sys_clk    (sys_clk),
    .srst       (srst),
    .hpd_sync   (hs2_r),
    .irq_pulse  (irq_p),
    .disc_pulse (disc_p),
    .conn_pulse (conn_p)
  );

  // register writes, reads, and sideband launch
  always_comb
  begin
    cmd_nxt  = cmd_r;
    tgt_nxt  = tgt_r;
    misc_nxt = misc_r;
    vm_nxt   = vm_r;
    vn_nxt   = vn_r;
    am_nxt   = am_r;
    an_nxt   = an_r;
    actl_nxt = actl_r;
    ach_nxt  = ach_r;
    sbv_nxt  = 1'b0;
    rd_nxt   = 32'h0000_0000;
    chg_nxt  = disc_p | conn_p;
    ist_nxt  = ist_r;
    // a read clears status; a new event in the same cycle still wins
    if (reg_req.rd && reg_req.addr == `OFS_INT_STATUS)
      ist_nxt = 2'b00;
    if (irq_p)
      ist_nxt[`INT_SINK_IRQ_BIT] = 1'b1;
    if (chg_nxt)
      ist_nxt[`INT_HOTPLUG_CHANGE_EVENT_BIT] = 1'b1;
    if (reg_req.wr)
      case (reg_req.addr)
        `OFS_SB_COMMAND:
        begin
          cmd_nxt = reg_req.wdata;
          sbv_nxt = 1'b1;
        end
        `OFS_SB_TARGET_ADDR: tgt_nxt  = reg_req.wdata;
        `OFS_STREAM_MISC:    misc_nxt = reg_req.wdata;
        `OFS_VID_M:          vm_nxt   = reg_req.wdata[23:0];
        `OFS_VID_N:          vn_nxt   = reg_req.wdata[23:0];
        `OFS_AUDIO_CONTROL:  actl_nxt = reg_req.wdata[7:0];
        `OFS_AUDIO_CHANNELS: ach_nxt  = reg_req.wdata[2:0];
        `OFS_AUDIO_M:        am_nxt   = reg_req.wdata[23:0];
        `OFS_AUDIO_N:        an_nxt   = reg_req.wdata[23:0];
        default: ;
      endcase
    if (reg_req.rd)
      case (reg_req.addr)
        `OFS_SB_COMMAND:     rd_nxt = cmd_r;
        `OFS_SB_TARGET_ADDR: rd_nxt = tgt_r;
        `OFS_STREAM_MISC:    rd_nxt = misc_r;
        `OFS_VID_M:          rd_nxt = {8'h00, vm_r};
        `OFS_VID_N:          rd_nxt = {8'h00, vn_r};
        `OFS_AUDIO_CONTROL:  rd_nxt = {24'h000000, actl_r};
        `OFS_AUDIO_CHANNELS: rd_nxt = {29'h0, ach_r};
        `OFS_AUDIO_M:        rd_nxt = {8'h00, am_r};
        `OFS_AUDIO_N:        rd_nxt = {8'h00, an_r};
        `OFS_INT_STATUS:     rd_nxt = {30'h0, ist_r};
        `OFS_HPD_STATE:      rd_nxt = {31'h0, hs2_r};
        default:             rd_nxt = 32'h0000_0000;
      endcase
  end

  // sideband request decode; address-only requests carry no length
  sb_req_t req_nxt;
  always_comb
  begin
    req_nxt.addr_only = cmd_nxt[`CMD_ADDR_ONLY_BIT];
    req_nxt.middle_of_transfer_flag       = cmd_nxt[`CMD_MOT_BIT];
    req_nxt.kind      = cmd_nxt[`CMD_CODE_MSB-1:`CMD_CODE_LSB];
    req_nxt.len       = cmd_nxt[`CMD_ADDR_ONLY_BIT] ? 4'h0
                      : cmd_nxt[`CMD_LEN_MSB:`CMD_LEN_LSB];
    req_nxt.target    = tgt_nxt;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      cmd_r  <= 32'h0;
      tgt_r  <= 32'h0;
      misc_r <= 32'h0;
      vm_r   <= 24'h0;
      vn_r   <= 24'h0;
      am_r   <= 24'h0;
      an_r   <= 24'h0;
      actl_r <= 8'h00;
      ach_r  <= 3'h0;
      ist_r  <= 2'b00;
      sb_req_valid <= 1'b0;
      sb_req <= '0;
      reg_rdata <= 32'h0;
      hotplug_change_event <= 1'b0;
      hpd_level <= 1'b0;
      tx_vid_m <= 24'h0;
      tx_vid_n <= 24'h0;
    end
    else
    begin
      cmd_r  <= cmd_nxt;
      tgt_r  <= tgt_nxt;
      misc_r <= misc_nxt;
      vm_r   <= vm_nxt;
      vn_r   <= vn_nxt;
      am_r   <= am_nxt;
      an_r   <= an_nxt;
      actl_r <= actl_nxt;
      ach_r  <= ach_nxt;
      ist_r  <= ist_nxt;
      sb_req_valid <= sbv_nxt;
      if (sbv_nxt)
        sb_req <= req_nxt;
      reg_rdata <= rd_nxt;
      hotplug_change_event <= chg_nxt;
      hpd_level <= hs2_r;
      // sync mode uses host values; async uses fixed n and interface m
      tx_vid_m <= misc_r[0] ? vm_r : clk_if_vid_m;
      tx_vid_n <= misc_r[0] ? vn_r : `VID_N_ASYNC;
    end
  end

  // ==========================================================
  // audio ingress buffer and packet former
  logic [23:0] smp_mem [BUF_DEPTH];
  logic [3:0]  wcnt_r, wcnt_nxt;
  logic [5:0]  bcnt_r, bcnt_nxt;
  logic        send_r, send_nxt, rdy_nxt, pv_nxt, pf_nxt;
  logic [7:0]  pb_nxt;
  logic        en;
  logic        take;
  logic [4:0]  pidx;

  assign en   = actl_r[0];
  assign take = aud_tvalid && aud_tready;
  assign pidx = 5'(bcnt_r - 6'(`PKT_HDR_BYTES + `PKT_HDR_PAR_BYTES));

  always_comb
  begin
    wcnt_nxt = wcnt_r;
    bcnt_nxt = bcnt_r;
    send_nxt = send_r;
    pv_nxt   = 1'b0;
    pf_nxt   = 1'b0;
    pb_nxt   = 8'h00;
    if (!en)
    begin
      wcnt_nxt = 4'h0;
      send_nxt = 1'b0;
      bcnt_nxt = 6'h0;
    end
    else if (!send_r)
    begin
      if (take)
        wcnt_nxt = wcnt_r + 4'h1;
      if (take && wcnt_r == 4'(BUF_DEPTH - 1))
        send_nxt = 1'b1;
    end
    else if (pkt_ready || !pkt_valid)
    begin
      pv_nxt = 1'b1;
      pf_nxt = bcnt_r == 6'h0;
      if (bcnt_r < 6'(`PKT_HDR_BYTES))
        pb_nxt = {5'h0, ach_r};
      else if (bcnt_r >= 6'(`PKT_HDR_BYTES + `PKT_HDR_PAR_BYTES)
            && bcnt_r < 6'(PKT_LEN - `PKT_PAY_PAR_BYTES))
        pb_nxt = 8'(smp_mem[pidx[4:2]] >> {pidx[1:0], 3'b000});
      bcnt_nxt = bcnt_r + 6'h1;
      if (bcnt_r == 6'(PKT_LEN - 1))
      begin
        bcnt_nxt = 6'h0;
        send_nxt = 1'b0;
        wcnt_nxt = 4'h0;
      end
    end
    rdy_nxt = en && !send_nxt && (wcnt_nxt < 4'(BUF_DEPTH));
  end

  always_ff @(posedge sys_clk)
  begin
    if (take && !send_r)
      smp_mem[wcnt_r[2:0]] <= aud_tdata[27:4];
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      wcnt_r     <= 4'h0;
      bcnt_r     <= 6'h0;
      send_r     <= 1'b0;
      aud_tready <= 1'b0;
      pkt_valid  <= 1'b0;
      pkt_byte   <= 8'h00;
      pkt_first  <= 1'b0;
      audio_mute <= 1'b1;
    end
    else
    begin
      wcnt_r     <= wcnt_nxt;
      bcnt_r     <= bcnt_nxt;
      send_r     <= send_nxt;
      aud_tready <= rdy_nxt;
      if (pkt_ready || !pkt_valid)
      begin
        pkt_valid <= pv_nxt;
        pkt_byte  <= pb_nxt;
        pkt_first <= pf_nxt;
      end
      audio_mute <= !en;                                // lags enable by one cycle
    end
  end

  // ==========================================================
  // checks
  a_mute_off_audio: assert property (@(posedge sys_clk) disable iff (srst)
    !en |=> audio_mute) else $error("mute not set while disabled");
  a_ready_disabled: assert property (@(posedge sys_clk) disable iff (srst)
    !en |=> !aud_tready) else $error("ready while disabled");
  a_sync_vid_n: assert property (@(posedge sys_clk) disable iff (srst)
    misc_r[0] |=> tx_vid_n == $past(vn_r)) else $error("sync n wrong");
  a_async_vid_n: assert property (@(posedge sys_clk) disable iff (srst)
    !misc_r[0] |=> tx_vid_n == `VID_N_ASYNC) else $error("async n wrong");
  a_cmd_launch: assert property (@(posedge sys_clk) disable iff (srst)
    reg_req.wr && reg_req.addr == `OFS_SB_COMMAND |=> sb_req_valid)
    else $error("command not launched");
  a_addr_only_len: assert property (@(posedge sys_clk) disable iff (srst)
    sb_req_valid && sb_req.addr_only |-> sb_req.len == 4'h0)
    else $error("address-only has length");
  a_mot_follow: assert property (@(posedge sys_clk) disable iff (srst)
    sb_req_valid |-> sb_req.middle_of_transfer_flag == cmd_r[`CMD_MOT_BIT]) else $error("mot lost");
  a_irq_status: assert property (@(posedge sys_clk) disable iff (srst)
    irq_p |=> ist_r[`INT_SINK_IRQ_BIT]) else $error("irq not flagged");
  a_eight_samples: assert property (@(posedge sys_clk) disable iff (srst)
    $rose(send_r) |-> $past(wcnt_r) == 4'h7) else $error("packet not at 8");
endmodule

// *** sim/sink_partner.sv ***
`timescale 1ns/1ns
// =====================================================
// far-side sink: drives hot-plug and paces packet bytes
module sink_partner (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // low pulse request from the bench
  input  wire logic        pulse_go,
  input  wire logic [15:0] pulse_len,
  // pins toward the source
  output logic             hpd_pin,
  output logic             pkt_ready
);
  logic [15:0] low_cnt_r;
  logic [1:0]  pace_r;
  // hold hot-plug low for the asked cycles, high while connected
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      low_cnt_r <= 16'h0000;
    else if (pulse_go)
      low_cnt_r <= pulse_len;
    else if (low_cnt_r != 16'h0000)
      low_cnt_r <= low_cnt_r - 16'h0001;
    pace_r <= srst ? 2'h0 : pace_r + 2'h1;
  end
  assign hpd_pin   = (low_cnt_r == 16'h0000);
  // stall one cycle in four so the byte stream has to wait
  assign pkt_ready = (pace_r != 2'h3);
endmodule

// *** sim/source_sideband_audio_ctrl_tb.sv ***
`timescale 1ns/1ns
`include "sideband_audio_params.svh"
module source_sideband_audio_ctrl_tb;
  import sideband_audio_pkg::*;
  typedef struct packed {
    logic [31:0] tgt;
    logic [31:0] cmd;
    sb_req_t     exp;
  } sb_row_t;
  logic        sys_clk = 1'b0;
  logic        srst = 1'b1;
  reg_req_t    reg_req = '0;
  logic [31:0] reg_rdata;
  logic        sb_req_valid;
  sb_req_t     sb_req;
  logic [23:0] clk_if_vid_m = 24'h0abcde;
  logic [23:0] tx_vid_m;
  logic [23:0] tx_vid_n;
  logic        hpd_pin;
  logic        hotplug_change_event;
  logic        hpd_level;
  logic        aud_tvalid = 1'b0;
  logic [31:0] aud_tdata = '0;
  logic        aud_tready;
  logic        pkt_ready;
  logic        pkt_valid;
  logic [7:0]  pkt_byte;
  logic        pkt_first;
  logic        audio_mute;
  logic        pulse_go = 1'b0;
  logic [15:0] pulse_len = '0;
  int          errors = 0;
  int          total_checks = 0;
  int          ev_cnt = 0;
  logic [31:0] rd;
  logic [7:0]  pkt [48];
  int          nb;
  // =====================================================
  // sideband commands, ordinary and address-only: target and command in, request out
  sb_row_t rows [8] = '{
    '{32'h50, 32'h0104, '{1'b0, 1'b0, 3'h1, 4'h4, 32'h50}},
    '{32'h50, 32'h0504, '{1'b0, 1'b1, 3'h5, 4'h4, 32'h50}},
    '{32'h50, 32'h0504, '{1'b0, 1'b1, 3'h5, 4'h4, 32'h50}},
    '{32'h51, 32'h0408, '{1'b0, 1'b1, 3'h4, 4'h8, 32'h51}},
    '{32'h51, 32'h0408, '{1'b0, 1'b1, 3'h4, 4'h8, 32'h51}},
    '{32'h51, 32'h1600, '{1'b1, 1'b1, 3'h6, 4'h0, 32'h51}},
    '{32'h51, 32'h1200, '{1'b1, 1'b0, 3'h2, 4'h0, 32'h51}},
    '{32'h52, 32'h1107, '{1'b1, 1'b0, 3'h1, 4'h0, 32'h52}}
  };
  // clock, 50 ns period
  always #25 sys_clk = ~sys_clk;
  always @(negedge sys_clk)
    if (hotplug_change_event === 1'b1)
      ev_cnt++;
  source_sideband_audio_ctrl #(.CLK_MHZ(1)) source_sideband_audio_ctrl_i (
    .sys_clk(sys_clk), .srst(srst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .sb_req_valid(sb_req_valid), .sb_req(sb_req), .clk_if_vid_m(clk_if_vid_m),
    .tx_vid_m(tx_vid_m), .tx_vid_n(tx_vid_n), .hpd_pin(hpd_pin),
    .hotplug_change_event(hotplug_change_event), .hpd_level(hpd_level),
    .aud_tvalid(aud_tvalid), .aud_tdata(aud_tdata), .aud_tready(aud_tready),
    .pkt_ready(pkt_ready), .pkt_valid(pkt_valid), .pkt_byte(pkt_byte),
    .pkt_first(pkt_first), .audio_mute(audio_mute));
  sink_partner sink_partner_i (
    .sys_clk(sys_clk), .srst(srst), .pulse_go(pulse_go), .pulse_len(pulse_len),
    .hpd_pin(hpd_pin), .pkt_ready(pkt_ready));
  // =====================================================
  // shared tasks
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // request rises on a falling edge and drops one cycle later
  task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
    @(negedge sys_clk);
    reg_req = '{1'b1, 1'b0, a, d};
    @(negedge sys_clk);
    reg_req = '0;
  endtask
  task automatic reg_rd(input logic [11:0] a, output logic [31:0] d);
    @(negedge sys_clk);
    reg_req = '{1'b0, 1'b1, a, 32'h0};
    @(negedge sys_clk);
    reg_req = '0;
    d = reg_rdata;
  endtask
  task automatic hpd_low(input logic [15:0] n, input int wait_cyc);
    @(negedge sys_clk);
    pulse_go = 1'b1;
    pulse_len = n;
    @(negedge sys_clk);
    pulse_go = 1'b0;
    repeat (wait_cyc) @(negedge sys_clk);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // =====================================================
  // main sequence
  initial
  begin
    repeat (2) @(negedge sys_clk);
    srst = 1'b0;
    check("mute_rst", 1, audio_mute);
    check("sbv_rst", 0, sb_req_valid);
    check("pkt_rst", 0, pkt_valid);
    foreach (rows[i])
    begin
      reg_wr(`OFS_SB_TARGET_ADDR, rows[i].tgt);
      reg_wr(`OFS_SB_COMMAND, rows[i].cmd);
      check("sb_valid", 1, sb_req_valid);
      check("sb_req", rows[i].exp, sb_req);
    end
    reg_rd(12'h3fc, rd);
    check("unmapped", 0, rd);
    // async clocking: fixed n, m from the clocking interface
    reg_wr(`OFS_STREAM_MISC, 32'h0);
    repeat (3) @(negedge sys_clk);
    check("vid_n_async", `VID_N_ASYNC, tx_vid_n);
    check("vid_m_async", clk_if_vid_m, tx_vid_m);
    reg_wr(`OFS_VID_M, 32'h123456);
    reg_wr(`OFS_VID_N, 32'h00789a);
    reg_wr(`OFS_STREAM_MISC, 32'h1);
    clk_if_vid_m = 24'h0fedcb;
    repeat (3) @(negedge sys_clk);
    check("vid_m_sync", 24'h123456, tx_vid_m);
    check("vid_n_sync", 24'h00789a, tx_vid_n);
    // audio: set up then stream eight samples
    reg_wr(`OFS_AUDIO_CHANNELS, 32'h1);
    reg_wr(`OFS_AUDIO_M, 32'h200);
    reg_wr(`OFS_AUDIO_N, 32'h8000);
    reg_wr(`OFS_AUDIO_CONTROL, 32'h1);
    @(negedge sys_clk);
    check("unmute", 0, audio_mute);
    for (int s = 0; s < 8; s++)
    begin
      aud_tvalid = 1'b1;
      aud_tdata = 32'h00abcd00 | (s << 4);
      for (int w = 0; w <= 200 && aud_tready !== 1'b1; w++)
        @(negedge sys_clk);
      if (aud_tready !== 1'b1)
      begin
        errors++;
        $display("CHECK FAILED aud_tready expected 1 seen %b", aud_tready);
        end_of_test();
      end
      @(negedge sys_clk);
    end
    aud_tvalid = 1'b0;
    nb = 0;
    for (int w = 0; w < 2000 && nb < 48; w++)
    begin
      if (pkt_valid === 1'b1 && pkt_ready === 1'b1)
      begin
        if (nb == 0)
          check("pkt_first", 1, pkt_first);
        pkt[nb] = pkt_byte;
        nb++;
      end
      @(negedge sys_clk);
    end
    check("pkt_len", 48, nb);
    for (int b = 0; b < 4; b++)
      check("hdr_chan", 1, pkt[b]);
    for (int b = 0; b < 4; b++)
      check("hdr_par", 0, pkt[4 + b]);
    for (int s = 0; s < 8; s++)
      check("samp_lsb", 8'hd0 | s, pkt[8 + 4 * s]);
    for (int b = 40; b < 48; b++)
      check("pay_par", 0, pkt[b]);
    reg_wr(`OFS_AUDIO_CONTROL, 32'h0);
    @(negedge sys_clk);
    check("mute", 1, audio_mute);
    check("tready_off", 0, aud_tready);
    // hot-plug: tick is 300 cycles with CLK_MHZ of 1
    repeat (1500) @(negedge sys_clk);
    reg_rd(`OFS_INT_STATUS, rd);
    hpd_low(16'd150, 2400);
    reg_rd(`OFS_INT_STATUS, rd);
    check("glitch", 0, rd[1:0]);
    hpd_low(16'd900, 2400);
    reg_rd(`OFS_INT_STATUS, rd);
    check("irq", 1, rd[1:0]);
    reg_rd(`OFS_INT_STATUS, rd);
    check("irq_clr", 0, rd[1:0]);
    nb = ev_cnt;
    hpd_low(16'd3000, 2600);
    check("disc_lvl", 0, hpd_level);
    check("disc_ev", nb + 1, ev_cnt);
    reg_rd(`OFS_INT_STATUS, rd);
    check("disc_int", 1, rd[1]);
    repeat (2400) @(negedge sys_clk);
    check("conn_lvl", 1, hpd_level);
    check("conn_ev", nb + 2, ev_cnt);
    end_of_test();
  end
endmodule
